// *** trc_timer.sv ***
// Reload/capture/toggle 16-bit timer with its special function registers
module trc_timer
   import trc_pkg::*;
(
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   // Register port
   input  wire trc_sfr_req_t sfr_req,
   output logic [7:0]        sfr_rdata,
   output logic              sfr_rvalid,
   // Pins
   input  wire logic         count_input_pin,
   input  wire logic         trigger_input,
   input  wire logic         ext_clock_pin,
   output logic              toggle_out,
   output logic              toggle_out_en
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic fell(input logic cur, input logic prev);
      fell = prev & ~cur;
   endfunction : fell

   function automatic logic hit(input trc_sfr_req_t r, input logic [7:0] a);
      hit = r.wr & (r.addr == a);
   endfunction : hit

   trc_state_t s;
   trc_state_t next_s;

   logic wr_ctl;
   logic wr_cfg;
   logic wr_rcl;
   logic wr_rch;
   logic wr_cl;
   logic wr_ch;
   logic clk_tick;
   logic step;
   logic down;
   logic ext_evt;
   logic wrap;
   logic at_wrap;

   // ****************************************
   // Event decode
   // ****************************************
   always_comb
   begin
      wr_ctl = hit(sfr_req, ADDR_CTL);
      wr_cfg = hit(sfr_req, ADDR_CFG);
      wr_rcl = hit(sfr_req, ADDR_RCL);
      wr_rch = hit(sfr_req, ADDR_RCH);
      wr_cl  = hit(sfr_req, ADDR_CNTL);
      wr_ch  = hit(sfr_req, ADDR_CNTH);
      case (s.clock_select) // R18
         CS_DIV12: clk_tick = (s.pre == PRE_LAST);
         CS_SYS:   clk_tick = 1'b1;
         CS_EXT8:  clk_tick = ~fell(s.ext_sync[1], s.ext_prev) & s.ext_sync[1]
                              & ~s.ext_prev & (s.ext_div == EXT_LAST);
         CS_DIV2:  clk_tick = s.pre[0];
         default:  clk_tick = 1'b0;
      endcase
      // Counter function counts falling count-pin edges
      step = s.run_control & (s.counter_timer_select // R15 R16
             ? fell(s.cnt_sync[1], s.cnt_prev) : clk_tick);
      down = s.decrement_enable & ~s.trg_sync[1]; // R14
      // Trigger edges only act with external enable set, decrement off
      ext_evt = s.external_trigger_enable & ~s.decrement_enable // R11
                & fell(s.trg_sync[1], s.trg_prev);
      if (s.capture_reload_select)
         at_wrap = down ? (s.count == CNT_MIN) : (s.count == CNT_MAX);
      else
         at_wrap = down ? (s.count == s.reload) : (s.count == CNT_MAX); // R2 R3
      wrap = step & at_wrap; // R8
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      next_s = s;
      // Synchronisers and edge history
      next_s.cnt_sync = {s.cnt_sync[0], count_input_pin}; // R22
      next_s.trg_sync = {s.trg_sync[0], trigger_input}; // R22
      next_s.ext_sync = {s.ext_sync[0], ext_clock_pin}; // R22
      next_s.cnt_prev = s.cnt_sync[1];
      next_s.trg_prev = s.trg_sync[1];
      next_s.ext_prev = s.ext_sync[1];
      // Prescalers run freely
      next_s.pre = (s.pre == PRE_LAST) ? 4'h0 : s.pre + 4'h1;
      if (s.ext_sync[1] & ~s.ext_prev)
         next_s.ext_div = s.ext_div + 3'h1;

      // Control register; hardware set beats software clear
      if (wr_ctl)
      begin
         next_s.external_trigger_enable = sfr_req.wdata[CTL_EXEN];
         next_s.run_control             = sfr_req.wdata[CTL_RUN];
         next_s.counter_timer_select    = sfr_req.wdata[CTL_CTSEL];
         next_s.capture_reload_select   = sfr_req.wdata[CTL_CPSEL]; // R17
         next_s.wrap_flag               = sfr_req.wdata[CTL_WRAP];
         next_s.external_event_flag     = sfr_req.wdata[CTL_EXTF];
      end
      if (wrap)
         next_s.wrap_flag = 1'b1; // R8 R9
      if (ext_evt)
         next_s.external_event_flag = 1'b1; // R10 R9

      // Configuration register
      if (wr_cfg)
      begin
         next_s.clock_select         = {sfr_req.wdata[CFG_CSHI], sfr_req.wdata[CFG_CSLO]};
         next_s.toggle_output_enable = sfr_req.wdata[CFG_OE];
         next_s.decrement_enable     = sfr_req.wdata[CFG_DCEN];
         next_s.toggle_state         = sfr_req.wdata[CFG_TOG]; // R6
      end
      else if (wrap & s.toggle_output_enable)
         next_s.toggle_state = ~s.toggle_state; // R1 R5 R7

      // Counter: trigger reload, then wrap, then plain step
      if (ext_evt & ~s.capture_reload_select)
         next_s.count = s.reload; // R13 R20
      else if (wrap)
         next_s.count = (s.capture_reload_select | down) ? (down ? CNT_MAX : CNT_MIN)
                        : s.reload; // R2 R3 R20
      else if (step)
         next_s.count = down ? s.count - 16'h0001 : s.count + 16'h0001; // R14
      if (wr_cl)
         next_s.count[7:0] = sfr_req.wdata; // R21
      if (wr_ch)
         next_s.count[15:8] = sfr_req.wdata; // R21

      // Reload/capture pair; a capture beats a software write
      if (wr_rcl)
         next_s.reload[7:0] = sfr_req.wdata;
      if (wr_rch)
         next_s.reload[15:8] = sfr_req.wdata;
      if (ext_evt & s.capture_reload_select)
         next_s.reload = s.count; // R12 R20

      // Read answer, one cycle after the strobe
      next_s.rvalid = sfr_req.rd;
      if (sfr_req.rd)
      begin
         case (sfr_req.addr)
            ADDR_CTL:  next_s.rdata = {s.wrap_flag, s.external_event_flag, 2'h0,
                                       s.external_trigger_enable, s.run_control,
                                       s.counter_timer_select, s.capture_reload_select};
            ADDR_CFG:  next_s.rdata = {3'h0, s.clock_select, s.toggle_state,
                                       s.toggle_output_enable, s.decrement_enable};
            ADDR_RCL:  next_s.rdata = s.reload[7:0];
            ADDR_RCH:  next_s.rdata = s.reload[15:8];
            ADDR_CNTL: next_s.rdata = s.count[7:0];
            ADDR_CNTH: next_s.rdata = s.count[15:8];
            default:   next_s.rdata = RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         s <= STATE_RST;
      else
         s <= next_s;
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign sfr_rdata     = s.rdata;
   assign sfr_rvalid    = s.rvalid;
   assign toggle_out    = s.toggle_state & s.toggle_output_enable; // R19
   assign toggle_out_en = s.toggle_output_enable; // R19

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   up_reload_a: assert property (step & ~down & ~s.capture_reload_select & at_wrap // R3
      & ~ext_evt & ~wr_cl & ~wr_ch |=> s.count == $past(s.reload) && s.wrap_flag)
      else $error("up overflow did not reload");
   down_reload_a: assert property (step & down & ~s.capture_reload_select // R2
      & (s.count == s.reload) & ~wr_cl & ~wr_ch |=> s.count == CNT_MAX)
      else $error("down underflow did not load all ones");
   toggle_flip_a: assert property (wrap & s.toggle_output_enable & ~wr_cfg // R1
      |=> s.toggle_state != $past(s.toggle_state))
      else $error("toggle missed a wrap");
   flag_hold_a: assert property (s.wrap_flag & ~wr_ctl |=> s.wrap_flag) // R9
      else $error("wrap flag cleared by hardware");
   ext_ignore_a: assert property (~s.external_trigger_enable & ~wr_ctl // R11
      & ~s.external_event_flag & ~wr_rcl & ~wr_rch
      |=> ~s.external_event_flag && s.reload == $past(s.reload))
      else $error("trigger acted while disabled");
   capture_copy_a: assert property (ext_evt & s.capture_reload_select // R12
      |=> s.reload == $past(s.count) ##0 s.external_event_flag)
      else $error("capture did not copy count");
   stop_hold_a: assert property (~s.run_control & ~ext_evt & ~wr_cl & ~wr_ch // R15
      |=> s.count == $past(s.count))
      else $error("stopped timer moved");
   tog_read_a: assert property (sfr_req.rd & (sfr_req.addr == ADDR_CFG) // R6
      |=> sfr_rvalid && sfr_rdata[CFG_TOG] == $past(s.toggle_state))
      else $error("toggle state read wrong");
   pin_hold_a: assert property (~s.toggle_output_enable |-> ~toggle_out_en && ~toggle_out) // R19
      else $error("toggle pin driven while withheld");

   // ****************************************
   // Checks of counting, pins and registers
   // ****************************************
   ext_flag_set_a: assert property (ext_evt // R10
      |=> s.external_event_flag)
      else $error("external flag not set by trigger");

   trig_reload_a: assert property (ext_evt & ~s.capture_reload_select & ~wr_cl & ~wr_ch // R13
      |=> s.count == $past(s.reload))
      else $error("trigger edge did not reload");

   ext_flag_hold_a: assert property (s.external_event_flag & ~wr_ctl // R9
      |=> s.external_event_flag)
      else $error("external flag cleared by hardware");

   dcen_refuse_a: assert property (s.decrement_enable & ~wr_ctl & ~s.external_event_flag // R13
      |=> ~s.external_event_flag)
      else $error("trigger acted while decrementing");

   up_step_a: assert property (step & ~down & ~at_wrap & ~ext_evt & ~wr_cl & ~wr_ch // R14
      |=> s.count == $past(s.count) + 16'h0001)
      else $error("up step wrong");

   down_step_a: assert property (step & down & ~at_wrap & ~wr_cl & ~wr_ch // R14
      |=> s.count == $past(s.count) - 16'h0001)
      else $error("down step wrong");

   up_only_a: assert property (~s.decrement_enable // R14
      |-> ~down)
      else $error("counted down without decrement enable");

   cnt_low_a: assert property (wr_cl // R21
      |=> s.count[7:0] == $past(sfr_req.wdata))
      else $error("count low byte write lost");

   cnt_high_a: assert property (wr_ch // R21
      |=> s.count[15:8] == $past(sfr_req.wdata))
      else $error("count high byte write lost");

   rc_low_a: assert property (wr_rcl & ~(ext_evt & s.capture_reload_select) // R20
      |=> s.reload[7:0] == $past(sfr_req.wdata))
      else $error("reload low byte write lost");

   rc_high_a: assert property (wr_rch & ~(ext_evt & s.capture_reload_select) // R20
      |=> s.reload[15:8] == $past(sfr_req.wdata))
      else $error("reload high byte write lost");

   cap_up_wrap_a: assert property (step & ~down & s.capture_reload_select // R8
      & (s.count == CNT_MAX) & ~wr_cl & ~wr_ch |=> s.count == CNT_MIN && s.wrap_flag)
      else $error("capture mode overflow wrong");

   cap_down_wrap_a: assert property (step & down & s.capture_reload_select // R8
      & (s.count == CNT_MIN) & ~wr_cl & ~wr_ch |=> s.count == CNT_MAX && s.wrap_flag)
      else $error("capture mode underflow wrong");

   cap_count_a: assert property (ext_evt & s.capture_reload_select & ~step // R12
      & ~wr_cl & ~wr_ch |=> s.count == $past(s.count))
      else $error("capture disturbed the count");

   div2_rate_a: assert property ((s.clock_select == CS_DIV2) & clk_tick & ~wr_cfg // R18
      |=> ~clk_tick)
      else $error("half rate ticks back to back");

   div12_rate_a: assert property ((s.clock_select == CS_DIV12) & clk_tick & ~wr_cfg // R18
      |=> ~clk_tick)
      else $error("twelfth rate ticks back to back");

   sys_rate_a: assert property ((s.clock_select == CS_SYS) & s.run_control // R18
      & ~s.counter_timer_select |-> step)
      else $error("full rate missed a step");

   pin_step_a: assert property (s.run_control & s.counter_timer_select // R16
      & fell(s.cnt_sync[1], s.cnt_prev) |-> step)
      else $error("count pin edge not counted");

   pin_count_a: assert property (s.run_control & s.counter_timer_select // R16
      & ~fell(s.cnt_sync[1], s.cnt_prev) |-> ~step)
      else $error("counted without a pin edge");

   sync_pipe_a: assert property (1'b1 // R22
      |=> s.trg_sync[1] == $past(s.trg_sync[0]))
      else $error("trigger synchroniser skipped a stage");

   toggle_idle_a: assert property (~wrap & ~wr_cfg // R1
      |=> s.toggle_state == $past(s.toggle_state))
      else $error("toggle moved without a wrap");

   toggle_force_a: assert property (wr_cfg // R6
      |=> s.toggle_state == $past(sfr_req.wdata[CFG_TOG]))
      else $error("toggle state not forced");

   oe_drive_a: assert property (s.toggle_output_enable // R19
      |-> toggle_out == s.toggle_state && toggle_out_en)
      else $error("enabled toggle not on pin");

   mode_write_a: assert property (wr_ctl // R17
      |=> s.capture_reload_select == $past(sfr_req.wdata[CTL_CPSEL])
      && s.run_control == $past(sfr_req.wdata[CTL_RUN]))
      else $error("control write lost");

   run_wrap_a: assert property (~s.run_control // R5
      |-> ~wrap)
      else $error("stopped timer wrapped");

endmodule : trc_timer

// *** trc_pkg.sv ***
// Constants, register map and state types of the reload/capture/toggle timer
//
// Overview of operation
// [R1] Toggle output inverts on every overflow or underflow while enabled.
// [R2] Down-counting reload: count equal to reload value underflows, loads 0xFFFF.
// [R3] Up-counting reload: passing 0xFFFF overflows and loads the reload value.
// [R4] Software selects reload mode, timer function and toggle enable for waves.
// [R5] Toggling starts once the run control bit is set.
// [R6] Toggle state bit reads the output level; writing forces it.
// [R7] Up reload square wave runs at timer clock over 2*(65536-reload).
// [R8] Wrap flag sets on overflow, reload underflow or capture underflow.
// [R9] Wrap and external flags stay set until software clears them.
// [R10] External flag sets when a falling trigger edge captures or reloads.
// [R11] With external enable clear, trigger transitions are ignored.
// [R12] Capture mode: falling trigger edge copies the count into reload/capture; the code captures only with decrement off.
// [R13] Reload mode, decrement off: falling trigger edge reloads, sets external flag.
// [R14] Decrement off counts up; on, trigger low counts down, high counts up.
// [R15] Run control zero stops the timer; one lets it count.
// [R16] Counter select zero counts timer clock; one counts count-pin falling edges.
// [R17] Capture/reload select zero is auto-reload, one is capture.
// [R18] Clock select: 00 sys/12, 01 sys, 10 external/8, 11 sys/2.
// [R19] Toggle output enable drives the waveform onto the pin or withholds it.
// [R20] Reload/capture pair takes captures and supplies the reload value.
// [R21] Count is 16 bits in separately accessible low and high bytes.
// [R22] Count, trigger and external clock inputs are synchronised before use.
package trc_pkg;

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [7:0] ADDR_CTL  = 8'hC8;
   localparam logic [7:0] ADDR_CFG  = 8'hC9;
   localparam logic [7:0] ADDR_RCL  = 8'hCA;
   localparam logic [7:0] ADDR_RCH  = 8'hCB;
   localparam logic [7:0] ADDR_CNTL = 8'hCC;
   localparam logic [7:0] ADDR_CNTH = 8'hCD;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTL_WRAP  = 7;
   localparam int CTL_EXTF  = 6;
   localparam int CTL_EXEN  = 3;
   localparam int CTL_RUN   = 2;
   localparam int CTL_CTSEL = 1;
   localparam int CTL_CPSEL = 0;
   localparam int CFG_CSHI  = 4;
   localparam int CFG_CSLO  = 3;
   localparam int CFG_TOG   = 2;
   localparam int CFG_OE    = 1;
   localparam int CFG_DCEN  = 0;

   // ****************************************
   // Clock selection and dividers
   // ****************************************
   localparam logic [1:0]  CS_DIV12 = 2'h0;
   localparam logic [1:0]  CS_SYS   = 2'h1;
   localparam logic [1:0]  CS_EXT8  = 2'h2;
   localparam logic [1:0]  CS_DIV2  = 2'h3;
   localparam logic [3:0]  PRE_LAST = 4'hB;
   localparam logic [2:0]  EXT_LAST = 3'h7;
   localparam logic [15:0] CNT_MAX  = 16'hFFFF;
   localparam logic [15:0] CNT_MIN  = 16'h0000;
   localparam logic [7:0]  RST_BYTE = 8'h00;

   // ****************************************
   // Carriers and state
   // ****************************************
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } trc_sfr_req_t;

   typedef struct packed {
      logic        wrap_flag;
      logic        external_event_flag;
      logic        external_trigger_enable;
      logic        run_control;
      logic        counter_timer_select;
      logic        capture_reload_select;
      logic [1:0]  clock_select;
      logic        toggle_state;
      logic        toggle_output_enable;
      logic        decrement_enable;
      logic [15:0] reload;
      logic [15:0] count;
      logic [3:0]  pre;
      logic [2:0]  ext_div;
      logic [1:0]  cnt_sync;
      logic [1:0]  trg_sync;
      logic [1:0]  ext_sync;
      logic        cnt_prev;
      logic        trg_prev;
      logic        ext_prev;
      logic [7:0]  rdata;
      logic        rvalid;
   } trc_state_t;

   localparam trc_state_t STATE_RST = '0;

endpackage : trc_pkg

// *** trc_pins_model.sv ***
// Pin-side model: count pin, trigger pin and external oscillator
module trc_pins_model
(
   // Clock
   input  wire logic clk_sys,
   // Pins
   output logic      count_input_pin,
   output logic      trigger_input,
   output logic      ext_clock_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      count_input_pin = 1'b1;
      trigger_input   = 1'b1;
      ext_clock_pin   = 1'b0;
   end

   // Free-running oscillator, 4 clk_sys per period
   always
   begin
      #80 ext_clock_pin = ~ext_clock_pin;
   end

   // Each level held 2 cycles so the synchroniser sees it
   task automatic pulse_count(input int n);
      repeat (n)
      begin
         repeat (2) @(negedge clk_sys);
         count_input_pin = 1'b0;
         repeat (2) @(negedge clk_sys);
         count_input_pin = 1'b1;
      end
   endtask : pulse_count

   task automatic set_trigger(input logic v);
      @(negedge clk_sys);
      trigger_input = v;
      repeat (4) @(negedge clk_sys);
   endtask : set_trigger
endmodule : trc_pins_model

// *** trc_timer_test.sv ***
// Self-checking bench of the reload/capture/toggle timer
module trc_timer_test
   import trc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic         clk_sys;
   logic         sys_rst;
   trc_sfr_req_t sfr_req;
   logic [7:0]   sfr_rdata, rv;
   logic         sfr_rvalid, count_input_pin, trigger_input;
   logic         ext_clock_pin, toggle_out, toggle_out_en;
   logic [15:0]  v, w, got;
   int           fails = 0;
   int           n_compared = 0;
   int           n, k;
   logic [1:0]   cs_list [4] = '{CS_SYS, CS_DIV2, CS_DIV12, CS_EXT8};

   always #20 clk_sys = ~clk_sys;

   trc_timer u_trc_timer (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .count_input_pin(count_input_pin),
      .trigger_input(trigger_input), .ext_clock_pin(ext_clock_pin),
      .toggle_out(toggle_out), .toggle_out_en(toggle_out_en));
   trc_pins_model u_trc_pins_model (.clk_sys(clk_sys), .count_input_pin(count_input_pin),
      .trigger_input(trigger_input), .ext_clock_pin(ext_clock_pin));

   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_req = '{a, 1'b1, 1'b0, d};
      @(negedge clk_sys);
      sfr_req.wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      sfr_req = '{a, 1'b0, 1'b1, 8'h00};
      @(negedge clk_sys);
      sfr_req.rd = 1'b0;
      check(sfr_rvalid, 16'h0001, "read valid");
      d = sfr_rdata;
   endtask : rd

   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(a + 8'h01, d[15:8]);
   endtask : wr16

   task automatic rd16(input logic [7:0] a, output logic [15:0] d);
      rd(a, d[7:0]);
      rd(a + 8'h01, d[15:8]);
   endtask : rd16

   task automatic measure(output int c);
      logic lvl;
      c = 0;
      lvl = toggle_out;
      while (toggle_out === lvl && c < 2000)
      begin
         @(negedge clk_sys);
         c++;
      end
   endtask : measure

   function automatic int half_cycles(input logic [1:0] cs);
      // 16 timer ticks per wrap; external clock is 4 clk_sys per period
      case (cs)
         CS_DIV12: return 16 * 12;
         CS_SYS:   return 16;
         CS_EXT8:  return 16 * 8 * 4;
         default:  return 16 * 2;
      endcase
   endfunction : half_cycles

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   // ****************
   // Tests
   // ****************
   initial
   begin
      clk_sys = 1'b0;
      sys_rst = 1'b1;
      sfr_req = '0;
      void'($urandom(32'h8F27));
      repeat (8) @(negedge clk_sys);
      sys_rst = 1'b0;
      for (int a = 8'hC8; a <= 8'hCE; a++)
      begin
         rd(8'(a), rv);
         check(rv, 16'h0000, "reset value");
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_CFG, 8'(i << 1));
         repeat (2) @(negedge clk_sys);
         check(toggle_out, 16'(i == 3), "toggle pin");
         check(toggle_out_en, 16'(i[0]), "pin enable");
         rd(ADDR_CFG, rv);
         check(rv, 16'(i << 1), "toggle state");
      end
      foreach (cs_list[j])
      begin
         wr16(ADDR_CNTL, 16'hFFF0);
         wr16(ADDR_RCL, 16'hFFF0);
         wr(ADDR_CFG, {3'h0, cs_list[j], 3'h2});
         wr(ADDR_CTL, 8'h04);
         measure(n);
         measure(n);
         check(16'(n), 16'(half_cycles(cs_list[j])), "half period");
         rd(ADDR_CTL, rv);
         check(rv, 16'h0084, "wrap flag");
         wr(ADDR_CTL, 8'h00);
         rd(ADDR_CTL, rv);
         check(rv, 16'h0000, "flag cleared");
      end
      wr(ADDR_CFG, 8'h01);
      repeat (3)
      begin
         v = 16'($urandom) & 16'h7FFF;
         n = 3 + $urandom % 4;
         k = 1 + $urandom % 2;
         u_trc_pins_model.set_trigger(1'b1);
         wr(ADDR_CTL, 8'h00);
         wr16(ADDR_CNTL, v);
         wr(ADDR_CTL, 8'h06);
         u_trc_pins_model.pulse_count(n);
         u_trc_pins_model.set_trigger(1'b0);
         u_trc_pins_model.pulse_count(k);
         rd16(ADDR_CNTL, w);
         check(w, v + 16'(n) - 16'(k), "pin count");
      end
      wr(ADDR_CTL, 8'h00);
      wr16(ADDR_CNTL, 16'h0004);
      wr16(ADDR_RCL, 16'h0003);
      wr(ADDR_CTL, 8'h06);
      u_trc_pins_model.pulse_count(2);
      rd(ADDR_CNTH, rv);
      check(rv, 16'h00FF, "down reload");
      rd(ADDR_CTL, rv);
      check(rv, 16'h0086, "underflow flag");
      wr(ADDR_CFG, 8'h00);
      u_trc_pins_model.set_trigger(1'b1);
      for (int m = 0; m < 4; m++)
      begin
         v = 16'($urandom);
         w = 16'($urandom);
         wr16(ADDR_RCL, w);
         wr16(ADDR_CNTL, v);
         wr(ADDR_CTL, 8'(m == 3 ? 8'h01 : 8'h08 | m[0]));
         u_trc_pins_model.set_trigger(1'b0);
         u_trc_pins_model.set_trigger(1'b1);
         rd16(m[0] ? ADDR_RCL : ADDR_CNTL, got);
         check(got, (m == 3) ? w : (m[0] ? v : w), "trigger edge");
         rd(ADDR_CTL, rv);
         check(rv, (m == 3) ? 16'h0001 : 16'(8'h48 | m[0]), "ext flag");
      end
      print_verdict();
   end

   initial
   begin
      #(40 * 60000);
      fails++;
      print_verdict();
   end
endmodule : trc_timer_test
